// *** pkg/atbc_defs.svh ***
// constants for the expansion bus control and arbitration block
`ifndef ATBC_DEFS_SVH
`define ATBC_DEFS_SVH
// ----------------------------------------
// bus timing, counted in bus clocks
// ----------------------------------------
`define ATBC_BUS_RATE_MHZ 8
`define ATBC_BUS_DIV 4
`define ATBC_LEN_MEM16_ZWS 4'h4
`define ATBC_LEN_MEM16_NWS 4'h6
`define ATBC_LEN_MEM8_ZWS 4'h6
`define ATBC_LEN_MEM8_NWS 4'hc
`define ATBC_LEN_IO16 4'h6
`define ATBC_LEN_IO8_ZWS 4'h6
`define ATBC_LEN_IO8_NWS 4'hc
// ----------------------------------------
// coprocessor clock dividers of the expansion clock source
// ----------------------------------------
`define ATBC_COPRO_DIV_FAST 2'h2
`define ATBC_COPRO_DIV_SLOW 2'h3
// ----------------------------------------
// non-cpu status codes: memory/io, data/control, write/read
// ----------------------------------------
`define ATBC_ST_REFRESH_READ 3'h1
`define ATBC_ST_MEM_WRITE 3'h2
`define ATBC_ST_MEM_READ 3'h3
`define ATBC_ST_REFRESH 3'h5
`define ATBC_ST_NONCPU 3'h6
`define ATBC_ST_IDLE 3'h7
// ----------------------------------------
// coprocessor i/o decode
// ----------------------------------------
`define ATBC_IO_ERR_CLEAR 8'hf0
`define ATBC_IO_COPRO_RESET 8'hf1
`define ATBC_IO_CS_BASE 5'h1f
`endif

// *** pkg/atbc_pkg.sv ***
// types shared by the expansion bus control and arbitration block
package atbc_pkg;
  typedef enum {ARB_IDLE, ARB_CPU_EXP, ARB_HOLD_WAIT, ARB_GRANTED, ARB_RELEASE} atbc_arb_type;
  typedef enum {OWN_NONE, OWN_REFRESH, OWN_DMA, OWN_MASTER, OWN_SLOW} atbc_owner_type;
endpackage : atbc_pkg

// *** src/atbc_cycle_timer.sv ***
// expansion bus cycle timer with ready stretch
`timescale 1ns/1ns
`include "atbc_defs.svh"
module atbc_cycle_timer (
  input wire logic clk_in, // system clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic bus_tick_in, // one pulse per bus clock
  input wire logic start_in, // begin a cycle
  input wire logic is_io_in, // 1 for i/o cycle
  input wire logic wide_in, // 1 for 16-bit target
  input wire logic zero_wait_in, // target asked for zero wait
  input wire logic ready_in, // iochrdy level
  output logic busy_out, // cycle in progress
  output logic cmd_active_out, // command phase
  output logic done_out // one-cycle end pulse
);
  logic [3:0] count;
  logic [3:0] length;

  function automatic logic [3:0] cycle_length(input logic io, input logic wide, input logic zws);
    if (io && wide) return `ATBC_LEN_IO16;
    if (io) return zws ? `ATBC_LEN_IO8_ZWS : `ATBC_LEN_IO8_NWS;
    if (wide) return zws ? `ATBC_LEN_MEM16_ZWS : `ATBC_LEN_MEM16_NWS;
    return zws ? `ATBC_LEN_MEM8_ZWS : `ATBC_LEN_MEM8_NWS;
  endfunction : cycle_length

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      busy_out <= 1'b0;
      count <= 4'h0;
      length <= 4'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (!busy_out && start_in) begin
        busy_out <= 1'b1;
        count <= 4'h0;
        length <= cycle_length(is_io_in, wide_in, zero_wait_in);
      end else if (busy_out && bus_tick_in) begin
        if (count == length - 4'h1) begin
          if (ready_in) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end

  assign cmd_active_out = busy_out && (count != 4'h0);

  a_timer_stretch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    busy_out && !ready_in && (count == length - 4'h1) |=> busy_out)
    else $error("cycle ended while target not ready");
endmodule : atbc_cycle_timer

// *** src/atbc_copro_clock.sv ***
// older coprocessor clock divider
`timescale 1ns/1ns
`include "atbc_defs.svh"
module atbc_copro_clock (
  input wire logic clk_in, // system clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic src_rise_in, // rising edge of the expansion clock source
  input wire logic enable_in, // older coprocessor present
  input wire logic clock_select_in, // 0: half rate, 1: third rate
  output logic older_copro_clock_out // divided clock
);
  logic [1:0] phase;
  logic [1:0] div;

  assign div = clock_select_in ? `ATBC_COPRO_DIV_SLOW : `ATBC_COPRO_DIV_FAST;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      phase <= 2'h0;
      older_copro_clock_out <= 1'b0;
    end else if (!enable_in) begin
      phase <= 2'h0;
      older_copro_clock_out <= 1'b0;
    end else if (src_rise_in) begin
      phase <= (phase >= div - 2'h1) ? 2'h0 : phase + 2'h1;
      older_copro_clock_out <= (phase == 2'h0);
    end
  end

  a_clock_third: assert property (@(posedge clk_in) disable iff (!resetn_in)
    enable_in && clock_select_in && src_rise_in && phase != 2'h0 |=> !older_copro_clock_out)
    else $error("third rate clock high too long");
endmodule : atbc_copro_clock

// *** src/atbc_top.sv ***
// expansion bus control, arbitration and coprocessor interface
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ns
`include "atbc_defs.svh"
module atbc_top (
  input wire logic clk_in, // 20 MHz system clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic expansion_clock_source_in, // 32 MHz source level
  input wire logic ads_n_in, // cpu address strobe, active low
  input wire logic cpu_mem_io_in, // 1 memory, 0 i/o
  input wire logic cpu_write_in, // 1 write
  input wire logic [15:0] cpu_address_in, // cpu address low bits
  input wire logic physical_address_top_bit_in, // address bit 31
  input wire logic local_memory_select_n_in, // local memory, active low
  input wire logic bus16_n_in, // target is 16 bit, active low
  input wire logic zero_wait_n_in, // target asks zero wait, active low
  input wire logic iochrdy_in, // target ready
  input wire logic refresh_request_tick_in, // refresh request pulse
  input wire logic refresh_active_n_in, // refresh indication, active low
  input wire logic dma_hold_request_in, // dma controller request
  input wire logic dma_command_in, // dma transfer strobe
  input wire logic dma_mem_to_io_in, // 1 memory to i/o
  input wire logic master_request_in, // bus master request
  input wire logic slow_speed_request_n_in, // slow speed request, active low
  input wire logic hlda_in, // cpu hold acknowledge
  input wire logic cpu_reset_in, // cpu reset level
  input wire logic coprocessor_present_n_in, // coprocessor installed, active low
  input wire logic copro_is_newer_in, // 1 newer type installed
  input wire logic newer_copro_busy_n_in, // newer busy, active low
  input wire logic newer_copro_operand_request_in, // newer operand request
  input wire logic newer_copro_error_n_in, // newer error, active low
  input wire logic older_copro_busy_n_in, // older busy, active low
  input wire logic older_copro_operand_request_in, // older operand request
  input wire logic older_copro_error_n_in, // older error, active low
  input wire logic copro_clock_select_in, // coprocessor clock select
  output logic hold_out, // hold request to cpu
  output logic hold_ack_status_out, // hold acknowledge status
  output logic dma_ack_out, // dma owns the bus
  output logic master_ack_out, // master owns the bus
  output logic slow_mode_out, // cpu held for slow speed
  output logic memr_n_out, // memory read command, active low
  output logic memw_n_out, // memory write command, active low
  output logic ior_n_out, // i/o read command, active low
  output logic iow_n_out, // i/o write command, active low
  output logic cpu_ready_n_out, // expansion cycle end, active low
  output logic refresh_address_enable_n_out, // refresh address enable, active low
  output logic [2:0] status_out, // memory/io, data/control, write/read
  output logic status_oe_n_out, // status driven, active low
  output logic coprocessor_type_select_n_out, // type select, active low
  output logic cpu_busy_n_out, // busy to cpu, active low
  output logic cpu_operand_request_out, // operand request to cpu
  output logic cpu_error_n_out, // error to cpu, active low
  output logic irq13_out, // coprocessor error interrupt
  output logic older_copro_chip_select_n_out, // older chip select, active low
  output logic older_copro_reset_out, // older coprocessor reset pulse
  output logic older_copro_clock_out // older coprocessor clock
);
  import atbc_pkg::*;

  // ----------------------------------------
  // bus clock from the expansion source
  // ----------------------------------------
  logic src_prev;
  logic src_rise;
  logic [1:0] src_count;
  logic bus_tick;

  assign src_rise = expansion_clock_source_in && !src_prev;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      src_prev <= 1'b0;
      src_count <= 2'h0;
    end else begin
      src_prev <= expansion_clock_source_in;
      if (src_rise) begin
        src_count <= src_count + 2'h1;
      end
    end
  end

  assign bus_tick = src_rise && (src_count == 2'(`ATBC_BUS_DIV - 1));

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  logic strobe;
  logic exp_cycle;
  logic io_write;
  logic [7:0] io_port;

  assign strobe = !ads_n_in;
  assign io_port = cpu_address_in[7:0];
  assign exp_cycle = strobe && (!cpu_mem_io_in || local_memory_select_n_in);
  assign io_write = strobe && !cpu_mem_io_in && cpu_write_in && (cpu_address_in[15:8] == 8'h00);

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  atbc_arb_type arb;
  atbc_owner_type owner;
  logic refresh_pending;
  logic refresh_done;
  logic timer_start;
  logic timer_busy;
  logic timer_cmd;
  logic timer_done;
  logic exp_io;
  logic exp_write;
  logic exp_wide;
  logic exp_zws;
  logic any_request;

  assign any_request = refresh_pending || dma_hold_request_in || master_request_in || !slow_speed_request_n_in;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      refresh_pending <= 1'b0;
    end else if (refresh_request_tick_in) begin
      refresh_pending <= 1'b1;
    end else if (arb == ARB_GRANTED && owner == OWN_REFRESH) begin
      refresh_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      arb <= ARB_IDLE;
      owner <= OWN_NONE;
      refresh_done <= 1'b0;
      exp_io <= 1'b0;
      exp_write <= 1'b0;
      exp_wide <= 1'b0;
      exp_zws <= 1'b0;
    end else begin
      unique case (arb)
        ARB_IDLE: begin
          if (exp_cycle) begin
            arb <= ARB_CPU_EXP;
            exp_io <= !cpu_mem_io_in;
            exp_write <= cpu_write_in;
            exp_wide <= !bus16_n_in;
            exp_zws <= !zero_wait_n_in;
          end else if (any_request) begin
            arb <= ARB_HOLD_WAIT;
            if (refresh_pending) owner <= OWN_REFRESH;
            else if (dma_hold_request_in) owner <= OWN_DMA;
            else if (master_request_in) owner <= OWN_MASTER;
            else owner <= OWN_SLOW;
          end
        end
        ARB_CPU_EXP: begin
          if (timer_done) arb <= ARB_IDLE;
        end
        ARB_HOLD_WAIT: begin
          refresh_done <= 1'b0;
          if (hlda_in) arb <= ARB_GRANTED;
        end
        ARB_GRANTED: begin
          if (timer_done) refresh_done <= 1'b1;
          unique case (owner)
            OWN_REFRESH: if (refresh_done && refresh_active_n_in) arb <= ARB_RELEASE;
            OWN_DMA: if (!dma_hold_request_in) arb <= ARB_RELEASE;
            OWN_MASTER: if (!master_request_in) arb <= ARB_RELEASE;
            OWN_SLOW: if (slow_speed_request_n_in) arb <= ARB_RELEASE;
            OWN_NONE: arb <= ARB_RELEASE;
          endcase
        end
        ARB_RELEASE: begin
          if (!hlda_in) begin
            arb <= ARB_IDLE;
            owner <= OWN_NONE;
          end
        end
      endcase
    end
  end

  // the done pulse still shows the old state for one clock: do not restart then
  assign timer_start = (arb == ARB_CPU_EXP && !timer_done) ||
                       (arb == ARB_GRANTED && owner == OWN_REFRESH && !refresh_done && !timer_done);

  atbc_cycle_timer u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .bus_tick_in(bus_tick),
    .start_in(timer_start),
    .is_io_in(arb == ARB_CPU_EXP && exp_io),
    .wide_in(arb != ARB_CPU_EXP || exp_wide),
    .zero_wait_in(arb != ARB_CPU_EXP || exp_zws),
    .ready_in(iochrdy_in),
    .busy_out(timer_busy),
    .cmd_active_out(timer_cmd),
    .done_out(timer_done)
  );

  // ----------------------------------------
  // commands and non-cpu status
  // ----------------------------------------
  logic granted;
  logic refresh_cmd;
  logic dma_cmd;

  assign granted = (arb == ARB_GRANTED) && hlda_in;
  assign refresh_cmd = granted && owner == OWN_REFRESH && timer_busy && timer_cmd;
  assign dma_cmd = granted && owner == OWN_DMA && dma_command_in;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      memr_n_out <= 1'b1;
      memw_n_out <= 1'b1;
      ior_n_out <= 1'b1;
      iow_n_out <= 1'b1;
      cpu_ready_n_out <= 1'b1;
    end else begin
      memr_n_out <= !((arb == ARB_CPU_EXP && timer_cmd && !exp_io && !exp_write) ||
                      refresh_cmd || (dma_cmd && dma_mem_to_io_in));
      memw_n_out <= !((arb == ARB_CPU_EXP && timer_cmd && !exp_io && exp_write) ||
                      (dma_cmd && !dma_mem_to_io_in));
      ior_n_out <= !((arb == ARB_CPU_EXP && timer_cmd && exp_io && !exp_write) ||
                     (dma_cmd && !dma_mem_to_io_in));
      iow_n_out <= !((arb == ARB_CPU_EXP && timer_cmd && exp_io && exp_write) ||
                     (dma_cmd && dma_mem_to_io_in));
      cpu_ready_n_out <= !(arb == ARB_CPU_EXP && timer_done);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      status_out <= `ATBC_ST_IDLE;
      status_oe_n_out <= 1'b1;
      refresh_address_enable_n_out <= 1'b1;
    end else begin
      status_oe_n_out <= !(hlda_in && arb != ARB_IDLE && arb != ARB_CPU_EXP);
      refresh_address_enable_n_out <= !(granted && owner == OWN_REFRESH && !refresh_done);
      if (refresh_cmd) begin
        status_out <= `ATBC_ST_REFRESH_READ;
      end else if (granted && owner == OWN_REFRESH && !refresh_done) begin
        status_out <= `ATBC_ST_REFRESH;
      end else if (dma_cmd) begin
        status_out <= dma_mem_to_io_in ? `ATBC_ST_MEM_READ : `ATBC_ST_MEM_WRITE;
      end else if (granted && owner == OWN_MASTER) begin
        status_out <= `ATBC_ST_NONCPU;
      end else begin
        status_out <= `ATBC_ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      hold_out <= 1'b0;
      hold_ack_status_out <= 1'b0;
      dma_ack_out <= 1'b0;
      master_ack_out <= 1'b0;
      slow_mode_out <= 1'b0;
    end else begin
      hold_out <= (arb == ARB_HOLD_WAIT) || (arb == ARB_GRANTED);
      hold_ack_status_out <= hlda_in;
      dma_ack_out <= granted && owner == OWN_DMA && dma_hold_request_in;
      master_ack_out <= granted && owner == OWN_MASTER && master_request_in;
      slow_mode_out <= granted && owner == OWN_SLOW;
    end
  end

  // ----------------------------------------
  // coprocessor interface
  // ----------------------------------------
  logic present;
  logic older;
  logic copro_busy;
  logic copro_error;
  logic busy_latch;
  logic err_clear;
  logic reset_prev;

  assign present = !coprocessor_present_n_in;
  assign older = present && !copro_is_newer_in;
  assign copro_busy = present && (copro_is_newer_in ? !newer_copro_busy_n_in : !older_copro_busy_n_in);
  assign copro_error = present && (copro_is_newer_in ? !newer_copro_error_n_in : !older_copro_error_n_in);
  assign err_clear = io_write && (io_port == `ATBC_IO_ERR_CLEAR ||
                                  (older && io_port == `ATBC_IO_COPRO_RESET));

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      busy_latch <= 1'b0;
    end else if (copro_busy && copro_error) begin
      busy_latch <= 1'b1;
    end else if (err_clear) begin
      busy_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cpu_busy_n_out <= 1'b1;
      cpu_operand_request_out <= 1'b0;
      cpu_error_n_out <= 1'b1;
      irq13_out <= 1'b0;
    end else begin
      cpu_busy_n_out <= !(copro_busy || busy_latch || (copro_busy && copro_error));
      cpu_operand_request_out <= present && (copro_is_newer_in ? newer_copro_operand_request_in :
                                             older_copro_operand_request_in);
      cpu_error_n_out <= !(older && !older_copro_error_n_in);
      irq13_out <= busy_latch || (copro_busy && copro_error);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      reset_prev <= 1'b0;
      coprocessor_type_select_n_out <= 1'b1;
    end else begin
      reset_prev <= cpu_reset_in;
      if (reset_prev && !cpu_reset_in) begin
        coprocessor_type_select_n_out <= 1'b0;
      end else if (strobe || cpu_reset_in) begin
        coprocessor_type_select_n_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      older_copro_chip_select_n_out <= 1'b1;
      older_copro_reset_out <= 1'b0;
    end else begin
      older_copro_chip_select_n_out <= !(older && strobe && !cpu_mem_io_in && physical_address_top_bit_in &&
                                         io_port[7:3] == `ATBC_IO_CS_BASE);
      older_copro_reset_out <= older && io_write && io_port == `ATBC_IO_COPRO_RESET;
    end
  end

  atbc_copro_clock u_copro_clock (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .src_rise_in(src_rise),
    .enable_in(older),
    .clock_select_in(copro_clock_select_in),
    .older_copro_clock_out(older_copro_clock_out)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_hold_granted;
    hold_out && hlda_in;
  endsequence

  a_grant_after_hlda: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(dma_ack_out) |-> $past(hlda_in))
    else $error("dma granted without hold acknowledge");
  a_refresh_memr: assert property (@(posedge clk_in) disable iff (!resetn_in)
    refresh_cmd |=> !memr_n_out && status_out == `ATBC_ST_REFRESH_READ)
    else $error("refresh without memory read");
  a_refresh_keep: assert property (@(posedge clk_in) disable iff (!resetn_in)
    arb == ARB_GRANTED && owner == OWN_REFRESH && !refresh_active_n_in |=> arb == ARB_GRANTED)
    else $error("refresh released while still active");
  a_dma_keep: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_hold_granted ##0 (arb == ARB_GRANTED && owner == OWN_DMA && dma_hold_request_in) |=> dma_ack_out)
    else $error("dma lost bus while requesting");
  a_status_only_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !hlda_in |=> status_oe_n_out)
    else $error("status driven without hold acknowledge");
  a_busy_latch_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    busy_latch && !err_clear |=> busy_latch ##1 (!cpu_busy_n_out && irq13_out))
    else $error("latched busy not held");
  a_irq_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    busy_latch && err_clear && !(copro_busy && copro_error) |=> !busy_latch)
    else $error("error latch not cleared");
  a_chip_select_decode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    older && strobe && !cpu_mem_io_in && !physical_address_top_bit_in |=> older_copro_chip_select_n_out)
    else $error("chip select without address top bit");
  a_local_no_cmd: assert property (@(posedge clk_in) disable iff (!resetn_in)
    arb == ARB_IDLE && strobe && cpu_mem_io_in && !local_memory_select_n_in |=> arb != ARB_CPU_EXP)
    else $error("local memory cycle sent to expansion bus");
endmodule : atbc_top

// *** tb/atbc_far_side.sv ***
// far side model: cpu hold acknowledge and slow i/o target
`timescale 1ns/1ns
module atbc_far_side (
  input wire logic clk_in, // system clock
  input wire logic hold_in, // hold request
  input wire logic stall_in, // make target slow
  output logic hlda_out, // hold acknowledge
  output logic iochrdy_out // target ready
);
  always_ff @(posedge clk_in) begin
    hlda_out <= hold_in;
  end
  assign iochrdy_out = ~stall_in;
endmodule : atbc_far_side

// *** tb/tb_at_bus_control_arbitration.sv ***
// self-checking bench for the expansion bus control block
`timescale 1ns/1ns
module tb_at_bus_control_arbitration;
  logic clk = 0, rstn = 0, src = 0, ads_n = 1, mio = 1, wr = 0, top = 0, loc_n = 1, b16_n = 0, zw_n = 0;
  logic tick = 0, ref_n = 1, dreq = 0, dcmd = 0, m2io = 1, mreq = 0, slow_n = 1, cp_n = 0, newer = 0;
  logic obusy_n = 1, oerr_n = 1, cksel = 0, stall = 0, hold, hlda, rdy, irdy, mr_n, iw_n, ref_en_n, irq, cs_n, dack;
  logic crst = 0, nbusy_n = 1, nerr_n = 1, oreq = 0, hack, mack, slw, mw_n, ir_n, oe_n, tsel_n, busy_n, opr, err_n;
  logic ocrst, cpclk;
  logic [15:0] addr = 16'h0000;
  logic [2:0] st;
  logic [4:0] seen;
  int failures = 0, n_tests = 0, len, l16, stl = 0, hi0 = 0, hi1 = 0;
  always #25 clk = ~clk;
  always #16 src = ~src;
  atbc_far_side far (.clk_in(clk), .hold_in(hold), .stall_in(stall), .hlda_out(hlda), .iochrdy_out(irdy));
  atbc_top DUT (.clk_in(clk), .resetn_in(rstn), .expansion_clock_source_in(src), .ads_n_in(ads_n),
    .cpu_mem_io_in(mio), .cpu_write_in(wr), .cpu_address_in(addr), .physical_address_top_bit_in(top),
    .local_memory_select_n_in(loc_n), .bus16_n_in(b16_n), .zero_wait_n_in(zw_n), .iochrdy_in(irdy),
    .refresh_request_tick_in(tick), .refresh_active_n_in(ref_n), .dma_hold_request_in(dreq),
    .dma_command_in(dcmd), .dma_mem_to_io_in(m2io), .master_request_in(mreq),
    .slow_speed_request_n_in(slow_n), .hlda_in(hlda), .cpu_reset_in(crst), .coprocessor_present_n_in(cp_n),
    .copro_is_newer_in(newer), .newer_copro_busy_n_in(nbusy_n), .newer_copro_operand_request_in(1'b0),
    .newer_copro_error_n_in(nerr_n), .older_copro_busy_n_in(obusy_n), .older_copro_operand_request_in(oreq),
    .older_copro_error_n_in(oerr_n), .copro_clock_select_in(cksel), .hold_out(hold),
    .hold_ack_status_out(hack), .dma_ack_out(dack), .master_ack_out(mack), .slow_mode_out(slw), .memr_n_out(mr_n),
    .memw_n_out(mw_n), .ior_n_out(ir_n), .iow_n_out(iw_n), .cpu_ready_n_out(rdy),
    .refresh_address_enable_n_out(ref_en_n), .status_out(st), .status_oe_n_out(oe_n),
    .coprocessor_type_select_n_out(tsel_n), .cpu_busy_n_out(busy_n), .cpu_operand_request_out(opr),
    .cpu_error_n_out(err_n), .irq13_out(irq), .older_copro_chip_select_n_out(cs_n),
    .older_copro_reset_out(ocrst), .older_copro_clock_out(cpclk));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic conclude;
    $display("failures %0d comparisons %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // one cpu cycle; len counts clocks until the ready pulse
  task automatic cyc(input logic m, input logic w, input logic b, input logic z, input logic [15:0] a);
    @(negedge clk);
    {mio, wr, b16_n, zw_n, addr, ads_n, seen} = {m, w, b, z, a, 1'b0, 5'h0};
    @(negedge clk);
    ads_n = 1;
    len = 0;
    while (rdy !== 1'b0 && len < 400) begin
      seen |= {ir_n === 1'b0, mw_n === 1'b0, ocrst === 1'b1, cs_n === 1'b0, mr_n === 1'b0 || iw_n === 1'b0};
      stall = (len < stl);
      @(negedge clk);
      len++;
    end
    stall = 0;
    chk_flag(len < 400, 1'b1);
  endtask : cyc
  // watch arbitration traffic, dropping requests at clock rel
  task automatic run(input int n, input int rel);
    seen = 5'h0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (i == rel) {ref_n, dreq, dcmd} = 3'b100;
      seen |= {hold === 1'b1, st === 3'h5 && ref_en_n === 1'b0, st === 3'h1 && mr_n === 1'b0,
        st === 3'h3 && mr_n === 1'b0 && iw_n === 1'b0, dack === 1'b1};
    end
  endtask : run
  initial begin
    #400000;
    failures++;
    conclude;
  end
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1;
    chk({hold, irq, ref_en_n}, 3'h1);
    chk(st, 3'h7);
    crst = 1;
    @(negedge clk);
    crst = 0;
    repeat (2) @(negedge clk);
    chk_flag(tsel_n, 1'b0);
    cyc(1, 0, 0, 0, 16'h1000);
    l16 = len;
    chk_flag(seen[0], 1'b1);
    chk_flag(tsel_n, 1'b1);
    cyc(1, 1, 1, 1, 16'h1000);
    chk_flag(len > l16, 1'b1);
    chk_flag(seen[3], 1'b1);
    cyc(1, 0, 0, 1, 16'h1000);
    chk_flag(len > l16, 1'b1);
    // local memory strobe: no expansion command may follow
    {mio, loc_n, ads_n} = 3'b100;
    @(negedge clk);
    {loc_n, ads_n} = 2'b11;
    repeat (20) @(negedge clk);
    chk_flag(mr_n, 1'b1);
    stl = 60;
    cyc(0, 1, 0, 1, 16'h0300);
    stl = 0;
    chk_flag(len >= 60, 1'b1);
    @(negedge clk);
    {tick, ref_n} = 2'b10;
    @(negedge clk);
    tick = 0;
    run(150, 80);
    chk(seen[4:2], 3'h7);
    chk_flag(hold, 1'b0);
    chk(st, 3'h7);
    {dreq, dcmd, m2io} = 3'h7;
    run(60, 40);
    chk_flag(seen[1], 1'b1);
    chk_flag(seen[0], 1'b1);
    chk_flag(dack, 1'b0);
    chk_flag(st inside {3'h3, 3'h6, 3'h7}, 1'b1);
    mreq = 1;
    repeat (20) @(negedge clk);
    chk_flag(mack, 1'b1);
    chk(st, 3'h6);
    chk_flag(oe_n, 1'b0);
    {mreq, slow_n} = 2'b00;
    repeat (20) @(negedge clk);
    chk_flag(mack, 1'b0);
    chk_flag(slw, 1'b1);
    chk_flag(hack, 1'b1);
    slow_n = 1;
    repeat (20) @(negedge clk);
    chk_flag(oe_n, 1'b1);
    {obusy_n, oerr_n, oreq} = 3'b001;
    @(negedge clk);
    chk_flag(err_n, 1'b0);
    chk_flag(opr, 1'b1);
    {obusy_n, oerr_n, oreq} = 3'b110;
    repeat (2) @(negedge clk);
    chk_flag(irq, 1'b1);
    chk_flag(busy_n, 1'b0);
    top = 1;
    cyc(0, 0, 1, 1, 16'h00fa);
    chk_flag(seen[1], 1'b1);
    chk_flag(seen[4], 1'b1);
    cyc(0, 1, 1, 1, 16'h00f1);
    chk_flag(seen[2], 1'b1);
    @(negedge clk);
    chk_flag(irq, 1'b0);
    chk_flag(busy_n, 1'b1);
    // high time of the divided clock: half rate first, then third rate
    for (int k = 0; k < 192; k++) begin
      @(negedge clk);
      cksel = (k >= 96);
      if (cksel) hi1 += cpclk;
      else hi0 += cpclk;
    end
    chk_flag(hi0 > hi1 + 8, 1'b1);
    chk_flag(hi1 > 16, 1'b1);
    newer = 1;
    {nbusy_n, nerr_n} = 2'b00;
    @(negedge clk);
    {nbusy_n, nerr_n} = 2'b11;
    repeat (2) @(negedge clk);
    chk_flag(irq, 1'b1);
    cyc(0, 1, 1, 1, 16'h00f1);
    chk_flag(irq, 1'b1);
    cyc(0, 1, 1, 1, 16'h00f0);
    @(negedge clk);
    chk_flag(irq, 1'b0);
    {cp_n, nbusy_n, nerr_n} = 3'b100;
    repeat (2) @(negedge clk);
    chk_flag(irq, 1'b0);
    conclude;
  end
endmodule : tb_at_bus_control_arbitration
